//--- rtl/sysctl_int_status_reset_cause.sv
// apb register bank: supervision event status, masking, interrupt and reset cause record
`timescale 1ns/1ps
`include "sysctl_regs.svh"
module sysctl_int_status_reset_cause
  import sysctl_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 power_on_resetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`ADDR_W-1:0]   paddr,
  input  wire logic [`DATA_W-1:0]   pwdata,
  input  wire logic [3:0]           pstrb,
  input  wire event_vec_t           event_in,
  input  wire reset_src_t           reset_source,
  output logic      [`DATA_W-1:0]   prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  output logic                      brownout_reset_req
);

  // address match against one register word
  function automatic logic hit(input logic [`ADDR_W-1:0] addr,
                               input logic [`ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  // any mapped register word
  function automatic logic mapped(input logic [`ADDR_W-1:0] addr);
    mapped = hit(addr, `OFF_BROWNOUT_CTRL) | hit(addr, `OFF_RAW_STATUS) |
             hit(addr, `OFF_EVENT_MASK) | hit(addr, `OFF_MASKED_STATUS) |
             hit(addr, `OFF_RESET_CAUSE);
  endfunction

  // event vector widened into a bus word, upper bits zero
  function automatic logic [`DATA_W-1:0] word_evt(input logic [`EVT_W-1:0] v);
    word_evt = {{(`DATA_W-`EVT_W){1'b0}}, v};
  endfunction

  logic [`EVT_W-1:0]   evt_level;
  logic [`EVT_W-1:0]   evt_rise;
  logic [`EVT_W-1:0]   raw_event_status;
  logic [`EVT_W-1:0]   event_mask_register;
  logic [`EVT_W-1:0]   masked_event_status;
  logic [`EVT_W-1:0]   masked_clear;
  logic [`EVT_W-1:0]   next_raw_event_status;
  logic [`CAUSE_W-1:0] reset_cause_record;
  logic [`CAUSE_W-1:0] next_reset_cause;
  logic                cause_captured;
  brownout_ctrl_t      brownout_control_register;
  logic                setup_seen;
  logic                access;
  logic                wr_lane0;
  logic [`DATA_W-1:0]  read_word;
  logic                rd_setup;
  logic                reg_hit;
  logic                sel_bo_ctrl;
  logic                sel_raw;
  logic                sel_mask;
  logic                sel_masked;
  logic                sel_cause;
  logic                wr_bo_ctrl;
  logic                wr_mask;
  logic                wr_clear;
  logic                wr_cause;
  logic                brownout_int_mask;
  logic                brownout_level;
  logic                pll_lock_masked_flag;
  logic                current_limit_masked_flag;
  logic                internal_osc_fault_masked_flag;
  logic                main_osc_fault_masked_flag;
  logic                regulator_unregulated_masked_flag;
  logic                brownout_masked_flag;
  logic                pll_fault_masked_flag;
  logic [`CAUSE_W-1:0] cause_from_reset;

  // event lines come from analog supervisors, so each is synchronised
  sync3_edge u_event_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (event_in),
    .level (evt_level),
    .rise  (evt_rise)
  );

  // ---- apb slave handshake ----

  // first access cycle samples the request, the next one completes it
  assign setup_seen = psel & penable & ~pready;
  assign access     = psel & penable & pready;
  assign wr_lane0   = access & pwrite & pstrb[0];

  // read request in its first access cycle
  assign rd_setup = setup_seen & ~pwrite;

  // register selects decoded once from the bus address
  assign sel_bo_ctrl = hit(paddr, `OFF_BROWNOUT_CTRL);
  assign sel_raw     = hit(paddr, `OFF_RAW_STATUS);
  assign sel_mask    = hit(paddr, `OFF_EVENT_MASK);
  assign sel_masked  = hit(paddr, `OFF_MASKED_STATUS);
  assign sel_cause   = hit(paddr, `OFF_RESET_CAUSE);
  assign reg_hit     = mapped(paddr);

  // write strobes at the completing edge; raw status takes no write
  assign wr_bo_ctrl = wr_lane0 & sel_bo_ctrl;
  assign wr_mask    = wr_lane0 & sel_mask;
  assign wr_clear   = wr_lane0 & sel_masked;
  assign wr_cause   = wr_lane0 & sel_cause;

  // one wait state on every transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_seen;
    end
  end

  // unmapped address answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_seen & ~reg_hit;
    end
  end

  // read multiplexer; reserved bits are returned as zero
  always_comb begin
    read_word = `RST_DATA;
    case (1'b1)
      sel_bo_ctrl: begin
        read_word = {{(`DATA_W-2){1'b0}}, brownout_control_register};
      end
      sel_raw: begin
        read_word = word_evt(raw_event_status);
      end
      sel_mask: begin
        read_word = word_evt(event_mask_register);
      end
      sel_masked: begin
        read_word = word_evt(masked_event_status);
      end
      sel_cause: begin
        read_word = {{(`DATA_W-`CAUSE_W){1'b0}}, reset_cause_record};
      end
      default: begin
        read_word = `RST_DATA;
      end
    endcase
  end

  // read data registered with the ready pulse, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_DATA;
    end else if (rd_setup) begin
      prdata <= read_word;
    end else begin
      prdata <= `RST_DATA;
    end
  end

  // ---- control registers ----

  // event mask, bits above the layout are dropped on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask_register <= `RST_EVT;
    end else if (wr_mask) begin
      event_mask_register <= pwdata[`EVT_W-1:0];
    end
  end

  // brown-out control: reset-instead-of-interrupt and an interrupt enable bit that is only stored and read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_control_register <= `RST_BO_CTRL;
    end else if (wr_bo_ctrl) begin
      brownout_control_register.brownout_reset_select <= pwdata[`BIT_BO_RESET_SEL];
      brownout_control_register.brownout_int_enable   <= pwdata[`BIT_BO_INT_ENABLE];
    end
  end

  // ---- event status ----

  // write-one clear of the masked register, lane 0 carries all bits
  always_comb begin
    masked_clear = `RST_EVT;
    if (wr_clear) begin
      masked_clear = pwdata[`EVT_W-1:0];
    end
  end

  // raw bits: set on a rising event, cleared through the masked register;
  // a set in the same cycle as its clear wins so no event is lost
  always_comb begin
    next_raw_event_status = (raw_event_status & ~masked_clear) | evt_rise;
  end

  // raw status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_event_status <= `RST_EVT;
    end else begin
      raw_event_status <= next_raw_event_status;
    end
  end

  // brown-out interrupt mask bit of the event mask register
  assign brownout_int_mask = event_mask_register[`BIT_BROWNOUT];

  // masked flags: raw and mask, brown-out further gated by its reset select
  assign pll_lock_masked_flag = raw_event_status[`BIT_PLL_LOCK] &
                                event_mask_register[`BIT_PLL_LOCK];
  assign current_limit_masked_flag = raw_event_status[`BIT_CURRENT_LIMIT] &
                                     event_mask_register[`BIT_CURRENT_LIMIT];
  assign internal_osc_fault_masked_flag = raw_event_status[`BIT_INT_OSC_FAULT] &
                                          event_mask_register[`BIT_INT_OSC_FAULT];
  assign main_osc_fault_masked_flag = raw_event_status[`BIT_MAIN_OSC_FAULT] &
                                      event_mask_register[`BIT_MAIN_OSC_FAULT];
  assign regulator_unregulated_masked_flag = raw_event_status[`BIT_UNREGULATED] &
                                             event_mask_register[`BIT_UNREGULATED];
  assign brownout_masked_flag = raw_event_status[`BIT_BROWNOUT] & brownout_int_mask &
                                ~brownout_control_register.brownout_reset_select;
  assign pll_fault_masked_flag = raw_event_status[`BIT_PLL_FAULT] &
                                 event_mask_register[`BIT_PLL_FAULT];

  // masked status word in the register layout; every bit is raw and mask, brown-out also needs reset select clear
  always_comb begin
    masked_event_status = `RST_EVT;
    masked_event_status[`BIT_PLL_LOCK]       = pll_lock_masked_flag;
    masked_event_status[`BIT_CURRENT_LIMIT]  = current_limit_masked_flag;
    masked_event_status[`BIT_INT_OSC_FAULT]  = internal_osc_fault_masked_flag;
    masked_event_status[`BIT_MAIN_OSC_FAULT] = main_osc_fault_masked_flag;
    masked_event_status[`BIT_UNREGULATED]    = regulator_unregulated_masked_flag;
    masked_event_status[`BIT_BROWNOUT]       = brownout_masked_flag;
    masked_event_status[`BIT_PLL_FAULT]      = pll_fault_masked_flag;
  end

  // level interrupt while any masked bit stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |masked_event_status;
    end
  end

  // filtered brown-out level, the same line that feeds the raw bit
  assign brownout_level = evt_level[`BIT_BROWNOUT];

  // brown-out turned into a reset request when reset-select is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_reset_req <= 1'b0;
    end else begin
      brownout_reset_req <= brownout_level & brownout_control_register.brownout_reset_select;
    end
  end

  // ---- reset cause record ----

  // marks that the sources of the last reset were taken in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_captured <= 1'b0;
    end else begin
      cause_captured <= 1'b1;
    end
  end

  // value left by the reset just ended: external stands alone, others pile up
  always_comb begin
    cause_from_reset = reset_cause_record | reset_source;
    if (reset_source.external_reset) begin
      cause_from_reset = `CAUSE_EXT_ONLY;
    end
  end

  // next cause value: capture after release, else software write
  always_comb begin
    next_reset_cause = reset_cause_record;
    if (!cause_captured) begin
      next_reset_cause = cause_from_reset;
    end else if (wr_cause) begin
      next_reset_cause = pwdata[`CAUSE_W-1:0];
    end
  end

  // survives every reset but power-on, which is the only constant load
  always_ff @(posedge pclk or negedge power_on_resetn) begin
    if (!power_on_resetn) begin
      reset_cause_record <= {`CAUSE_W{1'b0}};
    end else begin
      reset_cause_record <= next_reset_cause;
    end
  end

endmodule

//--- rtl/sysctl_regs.svh
// register map, field positions and reset values of the system-control status block
//
// Summary of operation
// - pll ready timer rising sets masked status bit 6 when its mask is on
// - regulator current-limit rising sets masked status bit 5 when masked in
// - internal oscillator fault sets masked status bit 4 when masked in
// - main oscillator fault sets masked status bit 3 when masked in
// - regulator going unregulated sets masked status bit 2 when masked in
// - brown-out shows on bit 1 only with mask set and reset-select clear
// - pll stopping oscillation sets masked status bit 0 when masked in
// - writing one clears a masked status bit; writing zero leaves it
// - reserved upper bits are undefined; software keeps them unchanged
// - reset cause value comes from the sources of the last reset
// - external pin reset sets bit 0 and clears every other cause bit
// - any other reset sets its cause bit and keeps earlier ones; the code clears them on power-on through power_on_resetn
// - cause bits: 5 regulator, 4 software, 3 watchdog, 2 brown-out, 1 power-on
// - masked bit is raw and mask, brown-out also needs reset-select clear; write-one clear also clears raw bit
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

`define ADDR_W              12
`define DATA_W              32
`define EVT_W               7
`define CAUSE_W             6

`define OFF_BROWNOUT_CTRL   12'h030
`define OFF_RAW_STATUS      12'h050
`define OFF_EVENT_MASK      12'h054
`define OFF_MASKED_STATUS   12'h058
`define OFF_RESET_CAUSE     12'h05c

`define BIT_PLL_LOCK        6
`define BIT_CURRENT_LIMIT   5
`define BIT_INT_OSC_FAULT   4
`define BIT_MAIN_OSC_FAULT  3
`define BIT_UNREGULATED     2
`define BIT_BROWNOUT        1
`define BIT_PLL_FAULT       0

`define BIT_BO_RESET_SEL    1
`define BIT_BO_INT_ENABLE   0

`define BIT_CAUSE_EXT       0

`define RST_EVT             7'h00
`define RST_BO_CTRL         2'h0
`define RST_DATA            32'h0000_0000
`define CAUSE_EXT_ONLY      6'h01

`endif

//--- rtl/sysctl_pkg.sv
// types shared by the system-control status block
`include "sysctl_regs.svh"
package sysctl_pkg;

  // supervision event lines, bit order matches the status layout
  typedef struct packed {
    logic pll_ready_timer;
    logic current_limit;
    logic internal_osc_fault;
    logic main_osc_fault;
    logic regulator_unregulated;
    logic brownout;
    logic pll_stopped;
  } event_vec_t;

  // reset sources of the reset just ended, bit order matches the cause layout
  typedef struct packed {
    logic regulator_power_lost;
    logic software_reset;
    logic watchdog_reset;
    logic brownout_reset;
    logic power_on_reset;
    logic external_reset;
  } reset_src_t;

  // brown-out control fields
  typedef struct packed {
    logic brownout_reset_select;
    logic brownout_int_enable;
  } brownout_ctrl_t;

endpackage

//--- rtl/sync3_edge.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`include "sysctl_regs.svh"
module sync3_edge (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [`EVT_W-1:0] d,
  output logic      [`EVT_W-1:0] level,
  output logic      [`EVT_W-1:0] rise
);

  logic [`EVT_W-1:0] stage1;
  logic [`EVT_W-1:0] stage2;
  logic [`EVT_W-1:0] stage3;

  // shift chain; stage1 feeds only stage2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= `RST_EVT;
      stage2 <= `RST_EVT;
      stage3 <= `RST_EVT;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // level follows only where second and third stage agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= `RST_EVT;
      rise  <= `RST_EVT;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
      rise  <= (stage2 & stage3) & ~level;
    end
  end

endmodule

//--- dv/sysctl_int_status_reset_cause_chk.sv
// concurrent checks on the ports of the system-control status block
`timescale 1ns/1ps
`include "sysctl_regs.svh"
module sysctl_chk
  import sysctl_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`DATA_W-1:0] pwdata,
  input wire logic [3:0]         pstrb,
  input wire reset_src_t         reset_source,
  input wire logic [`DATA_W-1:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               irq,
  input wire logic               brownout_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       done;
  logic       wr_ok;
  logic       rd_ok;
  logic [6:0] mask_q;
  logic       sel_q;
  logic       first_q;
  logic       ext_q;
  // completed transfers
  assign done  = psel && penable && pready;
  assign wr_ok = done && pwrite && pstrb[0];
  assign rd_ok = done && !pwrite && !pslverr;
  // shadow copies of mask and reset select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 7'h00;
      sel_q  <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == `OFF_EVENT_MASK) mask_q <= pwdata[6:0];
      if (paddr == `OFF_BROWNOUT_CTRL) sel_q <= pwdata[`BIT_BO_RESET_SEL];
    end
  end
  // marks the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_q <= 1'b0;
    else first_q <= 1'b1;
  end
  // remembers an external reset until software rewrites the cause record
  always_ff @(posedge pclk) begin
    if (presetn && !first_q) ext_q <= reset_source.external_reset;
    else if (wr_ok && paddr == `OFF_RESET_CAUSE) ext_q <= 1'b0;
  end
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_status_rsvd: assert property (rd_ok && paddr == `OFF_MASKED_STATUS
    |-> prdata[31:7] == 25'h0) else $error("status reserved bits not zero");
  a_cause_rsvd: assert property (rd_ok && paddr == `OFF_RESET_CAUSE
    |-> prdata[31:6] == 26'h0) else $error("cause reserved bits not zero");
  a_status_masked: assert property (rd_ok && paddr == `OFF_MASKED_STATUS
    |-> (prdata[6:0] & ~mask_q) == 7'h00) else $error("unmasked status bit shown");
  a_brownout_gate: assert property (rd_ok && paddr == `OFF_MASKED_STATUS && sel_q
    |-> !prdata[1]) else $error("brownout shown with reset select");
  a_ext_cause: assert property (rd_ok && paddr == `OFF_RESET_CAUSE && ext_q
    |-> prdata[5:0] == 6'h01) else $error("external cause not alone");
  a_irq_masked_off: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00
    |-> !irq) else $error("irq with all masks off");
  a_brown_req_sel: assert property (brownout_reset_req |-> sel_q || $past(sel_q))
    else $error("brownout reset request without select");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_bor_req: cover property (brownout_reset_req);
endmodule
bind sysctl_int_status_reset_cause sysctl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .reset_source(reset_source),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .brownout_reset_req(brownout_reset_req)
);

//--- dv/tb_top.sv
// register-level testbench of the system-control status block
`timescale 1ns/1ps
`include "sysctl_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import sysctl_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        power_on_resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [6:0]  ev;
  logic [5:0]  src;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        brownout_reset_req;
  logic [31:0] rd;
  logic        er;
  logic [5:0]  acc;
  int          errors = 0;
  int          compares = 0;
  sysctl_int_status_reset_cause u_dut (
    .pclk(pclk), .presetn(presetn), .power_on_resetn(power_on_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .event_in(event_vec_t'(ev)), .reset_source(reset_src_t'(src)),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .brownout_reset_req(brownout_reset_req)
  );
  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // one apb transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // reset with a given source set
  task automatic do_reset(input logic [5:0] s);
    src <= s; presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1; power_on_resetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic set_ev(input int i, input logic v);
    ev[i] <= v;
    repeat (10) @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end
  initial begin
    {presetn, power_on_resetn, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; ev = 7'h00;
    do_reset(6'h02);
    rchk(`OFF_RESET_CAUSE, 32'h2);
    apb(1'b1, `OFF_RESET_CAUSE, 32'h0000_003f);
    rchk(`OFF_RESET_CAUSE, 32'h3f);
    apb(1'b1, `OFF_RESET_CAUSE, 32'h0);
    acc = 6'h00;
    // causes pile up over non-external resets
    for (int i = 1; i < 6; i++) begin
      do_reset(6'h01 << i);
      acc |= 6'h01 << i;
      rchk(`OFF_RESET_CAUSE, {26'h0, acc});
    end
    do_reset(6'h09);
    rchk(`OFF_RESET_CAUSE, 32'h1);
    // every event sets, survives a zero write, clears by one
    apb(1'b1, `OFF_EVENT_MASK, 32'h7f);
    for (int i = 0; i < 7; i++) begin
      set_ev(i, 1'b1);
      set_ev(i, 1'b0);
      rchk(`OFF_MASKED_STATUS, 32'h1 << i);
      `CHK(irq, 1'b1)
      apb(1'b1, `OFF_MASKED_STATUS, ~(32'h1 << i) & 32'h7f);
      rchk(`OFF_MASKED_STATUS, 32'h1 << i);
      apb(1'b1, `OFF_MASKED_STATUS, 32'h1 << i);
      rchk(`OFF_MASKED_STATUS, 32'h0);
      rchk(`OFF_RAW_STATUS, 32'h0);
    end
    // masked off: raw only, then unmasked later
    apb(1'b1, `OFF_EVENT_MASK, 32'h0);
    set_ev(2, 1'b1);
    set_ev(2, 1'b0);
    rchk(`OFF_MASKED_STATUS, 32'h0);
    rchk(`OFF_RAW_STATUS, 32'h4);
    `CHK(irq, 1'b0)
    apb(1'b1, `OFF_EVENT_MASK, 32'h4);
    rchk(`OFF_MASKED_STATUS, 32'h4);
    apb(1'b1, `OFF_MASKED_STATUS, 32'h4);
    rchk(`OFF_RAW_STATUS, 32'h0);
    // brownout with reset select hides the masked bit
    apb(1'b1, `OFF_BROWNOUT_CTRL, 32'h3);
    rchk(`OFF_BROWNOUT_CTRL, 32'h3);
    apb(1'b1, `OFF_EVENT_MASK, 32'h2);
    set_ev(1, 1'b1);
    `CHK(brownout_reset_req, 1'b1)
    set_ev(1, 1'b0);
    rchk(`OFF_MASKED_STATUS, 32'h0);
    rchk(`OFF_RAW_STATUS, 32'h2);
    apb(1'b1, `OFF_BROWNOUT_CTRL, 32'h1);
    rchk(`OFF_MASKED_STATUS, 32'h2);
    // raw status takes no write; lane 0 off drops a mask write
    apb(1'b1, `OFF_RAW_STATUS, 32'h7f);
    rchk(`OFF_RAW_STATUS, 32'h2);
    pstrb <= 4'h0;
    apb(1'b1, `OFF_EVENT_MASK, 32'h0);
    pstrb <= 4'hf;
    rchk(`OFF_MASKED_STATUS, 32'h2);
    // unmapped place
    rchk(12'h100, 32'h0);
    `CHK(er, 1'b1)
    tally_and_finish();
  end
endmodule
